// file: rtl/pep_defines.vh
// timing counts, page geometry and command codes for the eeprom host controller
`ifndef PEP_DEFINES_VH
`define PEP_DEFINES_VH
`define PEP_CLK_MHZ        20
`define PEP_ADDR_W         11
`define PEP_DATA_W         8
`define PEP_PAGE_BYTES     64
`define PEP_PAGE_LSB       6
`define PEP_PROG_MAX_MS    3
`define PEP_PROG_CYC       (`PEP_PROG_MAX_MS * 1000 * 1000 * `PEP_CLK_MHZ / 1000)
`define PEP_ERASE_MS       10
`define PEP_ERASE_CYC      (`PEP_ERASE_MS * 1000 * 1000 * `PEP_CLK_MHZ / 1000)
`define PEP_STROBE_CYC     4
`define PEP_SETUP_CYC      2
`define PEP_READ_CYC       4
`define PEP_BIT_POLL       7
`define PEP_BIT_TOGGLE     6
`define PEP_BIT_TIMER      5
`define PEP_CMD_READ       2'h0
`define PEP_CMD_WRITE      2'h1
`define PEP_CMD_ERASE      2'h2
`define PEP_CMD_POLL       2'h3
`endif

// file: rtl/pep_page_buf.v
// page staging memory: 64 bytes, registered read
`timescale 1ns/1ns
`default_nettype none
`include "pep_defines.vh"
module pep_page_buf (
  // clock
  input  wire       mclk,
  // write side
  input  wire       wrEn,
  input  wire [5:0] wrAddr,
  input  wire [7:0] wrData,
  // read side
  input  wire [5:0] rdAddr,
  output reg  [7:0] rdData
);
  reg [7:0] mem [0:`PEP_PAGE_BYTES-1];
  always @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // pep_page_buf
`default_nettype wire

// file: rtl/pep_host_ctrl.v
// host controller driving a 2K x 8 parallel eeprom through its pins
`timescale 1ns/1ns
`default_nettype none
`include "pep_defines.vh"
module pep_host_ctrl (
  // clock and reset
  input  wire        mclk,
  input  wire        sys_rst,
  // user command port
  input  wire        cmdValid,
  output wire        cmdReady,
  input  wire [1:0]  cmdOp,
  input  wire [10:0] cmdAddr,
  input  wire [6:0]  cmdLen,
  output wire        fillReq,
  output reg  [5:0]  fillIdx,
  input  wire [7:0]  fillData,
  output reg         rspValid,
  output reg  [7:0]  rspData,
  output reg         rspTimeout,
  // device pins
  output reg  [10:0] locationSelect,
  input  wire [7:0]  byteLinesIn,
  output reg  [7:0]  byteLinesOut,
  output reg         byteLinesOe,
  output reg         chipSel_n,
  output reg         outEn_n,
  output reg         eraseHv,
  output reg         wrStrobe_n,
  input  wire        progDoneFlag
);
  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_FILL  = 4'h1;
  localparam [3:0] ST_WSET  = 4'h2;
  localparam [3:0] ST_WLOW  = 4'h3;
  localparam [3:0] ST_WHIGH = 4'h4;
  localparam [3:0] ST_RD    = 4'h5;
  localparam [3:0] ST_POLL  = 4'h6;
  localparam [3:0] ST_PGAP  = 4'h7;
  localparam [3:0] ST_ESET  = 4'h8;
  localparam [3:0] ST_ELOW  = 4'h9;
  localparam [3:0] ST_EWAIT = 4'ha;

  // counts are worked out at full width, then cut to the counter width
  localparam [31:0] PROG_FULL  = `PEP_PROG_CYC;
  localparam [31:0] ERASE_FULL = `PEP_ERASE_CYC;
  localparam [17:0] PROG_CYC   = PROG_FULL[17:0];
  localparam [17:0] ERASE_CYC  = ERASE_FULL[17:0];

  reg  [3:0]  state;
  reg  [17:0] cnt;
  reg  [17:0] busyCnt;
  reg  [6:0]  len;
  reg  [5:0]  idx;
  reg  [7:0]  lastData;
  reg  [10:0] baseAddr;
  wire [7:0]  bufData;

  function [10:0] pageAddr;
    input [10:0] base;
    input [5:0]  off;
    begin
      pageAddr = {base[10:6], off};
    end
  endfunction

  // buffer loads one byte per cycle while filling
  pep_page_buf uBuf (
    .mclk   (mclk),
    .wrEn   (state == ST_FILL),
    .wrAddr (fillIdx),
    .wrData (fillData),
    .rdAddr (idx),
    .rdData (bufData)
  );

  assign cmdReady = (state == ST_IDLE);
  assign fillReq  = (state == ST_FILL);

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      cnt <= 18'h0_0000;
      busyCnt <= 18'h0_0000;
      len <= 7'h00;
      idx <= 6'h00;
      fillIdx <= 6'h00;
      lastData <= 8'h00;
      baseAddr <= 11'h000;
      rspValid <= 1'b0;
      rspData <= 8'h00;
      rspTimeout <= 1'b0;
      locationSelect <= 11'h000;
      byteLinesOut <= 8'h00;
      byteLinesOe <= 1'b0;
      chipSel_n <= 1'b1;
      outEn_n <= 1'b1;
      eraseHv <= 1'b0;
      wrStrobe_n <= 1'b1;
    end else begin
      rspValid <= 1'b0;
      case (state)
        ST_IDLE: begin
          chipSel_n <= 1'b1;
          outEn_n <= 1'b1;
          byteLinesOe <= 1'b0;
          if (cmdValid) begin
            baseAddr <= cmdAddr;
            locationSelect <= cmdAddr;
            idx <= cmdAddr[5:0];
            fillIdx <= 6'h00;
            len <= (cmdLen == 7'h00 || cmdLen > 7'h40) ? 7'h01 : cmdLen;
            cnt <= 18'h0_0000;
            // a stand-alone poll gets a fresh 3 ms budget
            busyCnt <= 18'h0_0000;
            rspTimeout <= 1'b0;
            case (cmdOp)
              `PEP_CMD_WRITE: state <= ST_FILL;
              `PEP_CMD_ERASE: state <= ST_ESET;
              `PEP_CMD_POLL:  state <= ST_POLL;
              default:        state <= ST_RD;
            endcase
          end
        end
        ST_FILL: begin
          fillIdx <= fillIdx + 6'h01;
          if ({1'b0, fillIdx} + 7'h01 == len) begin
            idx <= 6'h00;
            state <= ST_WSET;
          end
        end
        ST_WSET: begin
          // address settles with output enable high before strobing
          locationSelect <= pageAddr(baseAddr, baseAddr[5:0] + idx);
          byteLinesOut <= bufData;
          byteLinesOe <= 1'b1;
          outEn_n <= 1'b1;
          chipSel_n <= 1'b0;
          cnt <= cnt + 18'h0_0001;
          if (cnt == `PEP_SETUP_CYC) begin
            cnt <= 18'h0_0000;
            wrStrobe_n <= 1'b0;
            state <= ST_WLOW;
          end
        end
        ST_WLOW: begin
          cnt <= cnt + 18'h0_0001;
          if (cnt == `PEP_STROBE_CYC) begin
            cnt <= 18'h0_0000;
            wrStrobe_n <= 1'b1;
            lastData <= byteLinesOut;
            state <= ST_WHIGH;
          end
        end
        ST_WHIGH: begin
          // next byte follows after the setup count with strobe high, well inside byte_load_timeout
          cnt <= cnt + 18'h0_0001;
          if (cnt == `PEP_SETUP_CYC) begin
            cnt <= 18'h0_0000;
            if ({1'b0, idx} + 7'h01 == len) begin
              chipSel_n <= 1'b1;
              byteLinesOe <= 1'b0;
              busyCnt <= 18'h0_0000;
              state <= ST_POLL;
            end else begin
              idx <= idx + 6'h01;
              state <= ST_WSET;
            end
          end
        end
        ST_RD: begin
          chipSel_n <= 1'b0;
          outEn_n <= 1'b0;
          wrStrobe_n <= 1'b1;
          byteLinesOe <= 1'b0;
          cnt <= cnt + 18'h0_0001;
          if (cnt == `PEP_READ_CYC) begin
            rspData <= byteLinesIn;
            rspValid <= 1'b1;
            outEn_n <= 1'b1;
            chipSel_n <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_POLL: begin
          // reads back the last byte; done once bit 7 matches the byte written and ready is seen
          chipSel_n <= 1'b0;
          outEn_n <= 1'b0;
          byteLinesOe <= 1'b0;
          busyCnt <= busyCnt + 18'h0_0001;
          cnt <= cnt + 18'h0_0001;
          if (cnt == `PEP_READ_CYC) begin
            cnt <= 18'h0_0000;
            outEn_n <= 1'b1;
            chipSel_n <= 1'b1;
            if (progDoneFlag &&
                byteLinesIn[`PEP_BIT_POLL] == lastData[`PEP_BIT_POLL]) begin
              rspData <= byteLinesIn;
              rspValid <= 1'b1;
              state <= ST_IDLE;
            end else if (busyCnt >= PROG_CYC) begin
              rspData <= byteLinesIn;
              rspTimeout <= 1'b1;
              rspValid <= 1'b1;
              state <= ST_IDLE;
            end else begin
              state <= ST_PGAP;
            end
          end
        end
        ST_PGAP: begin
          busyCnt <= busyCnt + 18'h0_0001;
          state <= ST_POLL;
        end
        ST_ESET: begin
          chipSel_n <= 1'b0;
          eraseHv <= 1'b1;
          cnt <= cnt + 18'h0_0001;
          if (cnt == `PEP_SETUP_CYC) begin
            cnt <= 18'h0_0000;
            wrStrobe_n <= 1'b0;
            state <= ST_ELOW;
          end
        end
        ST_ELOW: begin
          cnt <= cnt + 18'h0_0001;
          if (cnt + 18'h0_0001 == ERASE_CYC) begin
            cnt <= 18'h0_0000;
            wrStrobe_n <= 1'b1;
            state <= ST_EWAIT;
          end
        end
        ST_EWAIT: begin
          eraseHv <= 1'b0;
          chipSel_n <= 1'b1;
          rspValid <= 1'b1;
          rspData <= 8'hff;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // pep_host_ctrl
`default_nettype wire

// file: bench/pep_host_checker.sv
// port assertions for the eeprom host controller
`timescale 1ns/1ns
`default_nettype none
module pep_host_checker (
  // clock and reset
  input wire logic        mclk,
  input wire logic        sys_rst,
  // user side
  input wire logic        cmdValid,
  input wire logic        cmdReady,
  input wire logic [1:0]  cmdOp,
  input wire logic [10:0] cmdAddr,
  input wire logic        rspValid,
  // device pins
  input wire logic [10:0] locationSelect,
  input wire logic [7:0]  byteLinesOut,
  input wire logic        byteLinesOe,
  input wire logic        chipSel_n,
  input wire logic        outEn_n,
  input wire logic        eraseHv,
  input wire logic        wrStrobe_n,
  input wire logic        progDoneFlag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [6:0] tk;
  wire        take = cmdValid && cmdReady;
  wire        wr   = !wrStrobe_n && !eraseHv;
  // op and page of the command in flight
  always @(posedge mclk or posedge sys_rst)
    if (sys_rst) tk <= 7'h00;
    else if (take) tk <= {cmdOp, cmdAddr[10:6]};
  idle_deselect_a: assert property (cmdReady |-> chipSel_n)
    else $error("select low while idle");
  bus_release_a: assert property (byteLinesOe |-> outEn_n)
    else $error("host drives during read");
  read_shape_a: assert property (!outEn_n && !chipSel_n |-> wrStrobe_n && !byteLinesOe)
    else $error("bad read strobes");
  write_shape_a: assert property (wr |-> !chipSel_n && outEn_n && byteLinesOe)
    else $error("bad write strobes");
  strobe_width_a: assert property ($fell(wrStrobe_n) && !eraseHv |->
    !wrStrobe_n [*5] ##1 wrStrobe_n)
    else $error("strobe width");
  latch_hold_a: assert property (wr && $past(wr) |->
    $stable({locationSelect, byteLinesOut}))
    else $error("address or data moved");
  page_bits_a: assert property ($fell(wrStrobe_n) && tk[6:5] == 2'h1 |->
    locationSelect[10:6] == tk[4:0])
    else $error("page bits changed");
  // select and enable fall one edge after the take, the byte is answered four later
  read_time_a: assert property (take && cmdOp == 2'h0 |->
    ##2 !chipSel_n && !outEn_n ##4 rspValid)
    else $error("read timing");
  write_done_a: assert property (rspValid && tk[6:5] == 2'h1 |-> progDoneFlag)
    else $error("write ended while busy");
  erase_select_a: assert property (eraseHv |-> !chipSel_n && !byteLinesOe)
    else $error("erase pins");
  cover property (take && cmdOp == 2'h1);
  cover property (rspValid && tk[6:5] == 2'h3);
  cover property ($rose(eraseHv));
endmodule // pep_host_checker
bind pep_host_ctrl pep_host_checker u_pep_host_checker (.mclk, .sys_rst, .cmdValid,
  .cmdReady, .cmdOp, .cmdAddr, .rspValid, .locationSelect, .byteLinesOut, .byteLinesOe,
  .chipSel_n, .outEn_n, .eraseHv, .wrStrobe_n, .progDoneFlag);
`default_nettype wire

// file: bench/pep_eeprom_model.sv
// behavioural 2K x 8 eeprom on the far side of the controller
`timescale 1ns/1ns
`default_nettype none
module pep_eeprom_model #(
  parameter int LOAD = 40,
  parameter int PROG = 400
) (
  // timer clock
  input  wire logic        mclk,
  // device pins
  input  wire logic [10:0] locationSelect,
  input  wire logic [7:0]  busIn,
  output wire logic [7:0]  busOut,
  input  wire logic        chipSel_n,
  input  wire logic        outEn_n,
  input  wire logic        eraseHv,
  input  wire logic        wrStrobe_n,
  output wire logic        progDoneFlag
);
  logic [7:0]  mem [2048];
  logic [7:0]  last;
  logic [10:0] adr;
  logic        tog;
  int          tmr, busy;
  wire         rd = !chipSel_n && !outEn_n && wrStrobe_n;
  wire         st = tmr > 0 || busy > 0;
  wire  [7:0]  v  = st ? {~last[7], tog, busy > 0, 5'h00}
                       : mem[locationSelect];
  // released lines show the inverse, never a stale copy
  assign busOut = rd ? v : ~v;
  assign progDoneFlag = !st;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    {tmr, busy, tog, last} = 0;
  end
  always @(negedge wrStrobe_n) if (!chipSel_n && outEn_n) adr = locationSelect;
  always @(posedge outEn_n) if (st) tog <= !tog;
  // strobe updates land after the timer's own update in the same step, so a restart sticks
  always @(posedge wrStrobe_n)
    if (!chipSel_n && outEn_n && !eraseHv && busy == 0) begin
      mem[adr] <= busIn;
      last <= busIn;
      tmr <= 1;
      tog <= 0;
    end
  always @(posedge mclk) begin
    if (busy > 0) busy <= busy - 1;
    if (tmr == LOAD) begin
      tmr <= 0;
      busy <= PROG;
    end
    else if (tmr > 0) tmr <= tmr + 1;
  end
endmodule // pep_eeprom_model
`default_nettype wire

// file: bench/pep_host_ctrl_test.sv
// self-checking bench for the eeprom host controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin nChecks++; if ((s) !== (e)) begin badCount++; \
  $display("unexpected %s expected %h seen %h", n, e, s); end end
module pep_host_ctrl_test;
  logic        mclk, sys_rst, cmdValid, cmdReady, fillReq, rspValid, rspTimeout;
  logic        byteLinesOe, chipSel_n, outEn_n, eraseHv, wrStrobe_n, progDoneFlag;
  logic [1:0]  cmdOp;
  logic [10:0] cmdAddr, locationSelect, a;
  logic [6:0]  cmdLen;
  logic [5:0]  fillIdx;
  logic [7:0]  fillData, rspData, byteLinesOut, devOut, fb [64];
  int          badCount, nChecks, n;
  wire  [7:0]  byteLinesIn = byteLinesOe ? byteLinesOut : devOut;
  pep_host_ctrl u_pep_host_ctrl (.mclk, .sys_rst, .cmdValid, .cmdReady, .cmdOp, .cmdAddr,
    .cmdLen, .fillReq, .fillIdx, .fillData, .rspValid, .rspData, .rspTimeout,
    .locationSelect, .byteLinesIn, .byteLinesOut, .byteLinesOe, .chipSel_n, .outEn_n,
    .eraseHv, .wrStrobe_n, .progDoneFlag);
  pep_eeprom_model u_pep_eeprom_model (.mclk, .locationSelect, .busIn(byteLinesIn),
    .busOut(devOut), .chipSel_n, .outEn_n, .eraseHv, .wrStrobe_n, .progDoneFlag);
  always #25 mclk = !mclk;
  always @(negedge mclk) if (fillReq) fillData <= fb[fillIdx];
  function automatic logic [10:0] pg(input logic [10:0] b, input int i);
    return {b[10:6], b[5:0] + 6'(i)};
  endfunction
  task automatic go(input logic [1:0] op, input logic [10:0] ad, input int len);
    {cmdOp, cmdAddr, cmdLen, cmdValid} = {op, ad, 7'(len), 1'b1};
    @(negedge mclk) cmdValid = 1'b0;
  endtask
  task automatic wt;
    int w;
    w = 0;
    while (rspValid !== 1'b1 && w < 9000) begin
      @(negedge mclk);
      w++;
    end
    if (w == 9000) begin
      badCount++;
      finishTest;
    end
    @(negedge mclk);
  endtask
  task automatic finishTest;
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge mclk);
    badCount++;
    finishTest;
  end
  initial begin
    {mclk, cmdValid, cmdOp, cmdAddr, cmdLen, fillData, badCount, nChecks} = 0;
    sys_rst = 1;
    n = $urandom(32'h4eba);
    repeat (6) @(negedge mclk);
    `CHK("idle strobes", 3'b111, {chipSel_n, outEn_n, wrStrobe_n})
    `CHK("reset drive", 1'b0, byteLinesOe)
    sys_rst = 0;
    @(negedge mclk);
    go(0, 11'h7ff, 1);
    wt;
    `CHK("blank byte", 8'hff, rspData)
    for (int t = 0; t < 6; t++) begin
      a = t == 0 ? 11'h03c : 11'($urandom);
      n = t == 0 ? 8 : t == 1 ? 64 : t == 2 ? 1 : 1 + $urandom % 64;
      foreach (fb[i]) fb[i] = 8'($urandom);
      go(1, a, n);
      wt;
      `CHK("write limit", 1'b0, rspTimeout)
      `CHK("write end", fb[n - 1], rspData)
      go(3, pg(a, n - 1), 1);
      wt;
      `CHK("poll byte", fb[n - 1], rspData)
      `CHK("poll limit", 1'b0, rspTimeout)
      for (int i = 0; i < n; i++) begin
        go(0, pg(a, i), 1);
        wt;
        `CHK("read back", fb[i], rspData)
      end
    end
    // erase is cut short by a reset in mid-pulse
    go(2, 11'h000, 1);
    repeat (10) @(negedge mclk);
    `CHK("erase pins", 4'b1000, {eraseHv, chipSel_n, wrStrobe_n, byteLinesOe})
    sys_rst = 1;
    repeat (6) @(negedge mclk);
    sys_rst = 0;
    @(negedge mclk);
    `CHK("after abort", 3'b011, {eraseHv, cmdReady, chipSel_n})
    finishTest;
  end
endmodule // pep_host_ctrl_test
`default_nettype wire
